// ===== rtl/fidc_defines.svh
// Opcodes, identity values, timing counts and host register map
`ifndef FIDC_DEFINES_SVH
`define FIDC_DEFINES_SVH
`define FIDC_CLK_NS        40
`define FIDC_SCLK_HALF     3'h4
`define FIDC_OP_WRSR       8'h01
`define FIDC_OP_PP         8'h02
`define FIDC_OP_WRITE_ENABLE_CMD       8'h06
`define FIDC_OP_SE         8'h20
`define FIDC_OP_QPP        8'h32
`define FIDC_OP_SR_PROG    8'h42
`define FIDC_OP_SR_ERASE   8'h44
`define FIDC_OP_UID        8'h4B
`define FIDC_OP_BE32       8'h52
`define FIDC_OP_CE1        8'h60
`define FIDC_OP_SUSP       8'h75
`define FIDC_OP_RESUME     8'h7A
`define FIDC_OP_QIO_ID     8'h94
`define FIDC_OP_READ_IDENTITY_CMD       8'h9F
`define FIDC_OP_CE2        8'hC7
`define FIDC_OP_BE64       8'hD8
// Identity values are arbitrary
`define FIDC_MFR_ID        8'hA5
`define FIDC_MEM_TYPE      8'h60
`define FIDC_MEM_CAP       8'h15
`define FIDC_DEV_ID        8'h14
`define FIDC_UID           128'h0123456789ABCDEF0F1E2D3C4B5A6978
// Suspend latency, sector erase time, page program time
`define FIDC_SUSP_NS       20000
`define FIDC_SUSP_CYC      (`FIDC_SUSP_NS / `FIDC_CLK_NS)
`define FIDC_SE_TIME_NS    60000
`define FIDC_SE_CYC        (`FIDC_SE_TIME_NS / `FIDC_CLK_NS)
`define FIDC_PP_TIME_NS    20000
`define FIDC_PP_CYC        (`FIDC_PP_TIME_NS / `FIDC_CLK_NS)
// Host controller registers
`define FIDC_REG_CMD       8'h00
`define FIDC_REG_ADDR      8'h04
`define FIDC_REG_WDATA     8'h08
`define FIDC_REG_RDATA     8'h0C
`define FIDC_REG_STATUS    8'h10
`define FIDC_CMD_ADDR      8
`define FIDC_CMD_QUAD      9
`define FIDC_CMD_DUMMY     10
`define FIDC_CMD_TX        11
`define FIDC_CMD_NB_LSB    16
`endif

// ===== rtl/fidc_pkg.sv
// State types of the flash command block and its host controller
`default_nettype none
package fidc_pkg;
  typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR, D_DUMMY, D_OUT, D_DIN, D_WAITCS, D_IGNORE} fidc_dev_st_t;
  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_ERASE, OP_SPROG, OP_SERASE} fidc_op_t;
  typedef enum logic [2:0] {H_IDLE, H_OPC, H_ADDR, H_DUMMY, H_DATA, H_GAP} fidc_host_st_t;

  typedef struct packed {
    logic [1:0]                 s_sclk;
    logic [1:0]                 s_cs;
    logic [1:0][3:0]            s_io;
    logic                       sclk_d;
    fidc_dev_st_t               st;
    logic [7:0]                 opc;
    logic [23:0]                addr;
    logic [4:0]                 cnt;
    logic [3:0]                 bidx;
    logic [7:0]                 sr;
    logic                       quad;
    logic                       nd;
    logic [3:0]                 out;
    logic [3:0]                 oe_n;
    logic                       write_in_progress;
    logic                       write_enable_latch;
    logic                       sus_p;
    logic                       sus_e;
    fidc_op_t                   op;
    logic [11:0]                timer;
    logic [9:0]                 lat;
    logic                       refused;
    logic [2:0][511:0][7:0]     mem;
  } fidc_dev_t;

  typedef struct packed {
    logic [1:0][3:0]            s_io;
    fidc_host_st_t              st;
    logic [2:0]                 div;
    logic                       sclk;
    logic                       cs_n;
    logic [23:0]                sr;
    logic [10:0]                cnt;
    logic [31:0]                rx;
    logic [3:0]                 out;
    logic [3:0]                 oe_n;
    logic [23:0]                cmd;
    logic [23:0]                addr;
    logic [7:0]                 wdata;
    logic [31:0]                prdata;
  } fidc_host_t;
endpackage : fidc_pkg
`default_nettype wire

// ===== rtl/fidc_link_if.sv
// Serial flash link between host controller and flash command block
`default_nettype none
interface fidc_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe_n;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe_n;
  logic [3:0] io;

  // Wire level per line, pulled high when undriven
  for (genvar i = 0; i < 4; i++) begin : g_res
    assign io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
  end

  modport host (output cs_n, output sclk, output h_io_o, output h_io_oe_n, input io);
  modport dev  (input cs_n, input sclk, input io, output d_io_o, output d_io_oe_n);
endinterface : fidc_link_if
`default_nettype wire

// ===== rtl/fidc_flash.sv
// Flash command block: ID reads, suspend/resume, security registers
// Function
// - Quad ID read: zero address, IDs on four lines
// - Address one returns device ID first
// - ID read: manufacturer, memory type, capacity
// - ID read ignored while cycle runs
// - Host avoids ID read in deep power-down
// - ID shifted on falling edges, CS ends
// - Suspend only during program/erase, not suspended
// - Suspend flag immediate, busy clears after latency
// - Program suspend refuses writes, erases, programs
// - Erase suspend refuses status write, erases
// - Power loss clears suspended state
// - Resume only when suspended and idle
// - Resume clears suspend, sets busy, continues
// - Unique ID: zero address, dummy, 128 bits
// - Three independent 512-byte security registers
// - Register erase needs latch, exact length
// - CS rise starts timed cycle, clears latch
// - Register chosen by address bits 15-12
// - Locked register ignores erase
// - Register program: enable, address, data bytes
// - Locked register ignores program
// - Bits 8-0 give byte within register
//
// Added by the designer: the APB slave port and the register offsets.
`default_nettype none
`include "fidc_defines.svh"
module fidc_flash (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // Serial link
  fidc_link_if.dev         lk,
  // Array side
  input  wire logic [2:0]  otp_lock_bits_i,
  input  wire logic        array_prog_start_i,
  input  wire logic        array_erase_start_i,
  output logic             write_in_progress_o,
  output logic             write_enable_latch_o,
  output logic [1:0]       suspend_flags_o,
  output logic             cmd_refused_o
);
  fidc_pkg::fidc_dev_t q;
  fidc_pkg::fidc_dev_t n;
  logic       sclk;
  logic       cs_n;
  logic [3:0] di;
  logic       rise;
  logic       fall;
  logic       sus;
  logic       sec_ok;
  logic       lock;
  logic [1:0] sel;

  assign sclk = q.s_sclk[1];
  assign cs_n = q.s_cs[1];
  assign di   = q.s_io[1];
  assign rise = sclk & ~q.sclk_d;
  assign fall = ~sclk & q.sclk_d;
  assign sus  = q.sus_p | q.sus_e;
  assign sel  = q.addr[13:12] - 2'h1;
  assign sec_ok = (q.addr[23:16] == 8'h00) && (q.addr[15:14] == 2'h0) && (q.addr[13:12] != 2'h0)
                  && (q.addr[11:9] == 3'h0);
  assign lock = otp_lock_bits_i[sel];

  function automatic logic blocked(input logic [7:0] op, input logic sp, input logic se);
    logic common;
    common = (op == `FIDC_OP_WRSR) || (op == `FIDC_OP_SR_ERASE) || (op == `FIDC_OP_SE) || (op == `FIDC_OP_BE32)
             || (op == `FIDC_OP_BE64) || (op == `FIDC_OP_CE1) || (op == `FIDC_OP_CE2);
    blocked = ((sp | se) & common)
              | (sp & ((op == `FIDC_OP_SR_PROG) || (op == `FIDC_OP_PP) || (op == `FIDC_OP_QPP)));
  endfunction : blocked

  function automatic logic [7:0] id_byte(input logic [7:0] op, input logic a0, input logic [3:0] idx);
    logic [127:0] uid;
    uid = `FIDC_UID;
    if (op == `FIDC_OP_READ_IDENTITY_CMD) begin
      id_byte = (idx == 4'h0) ? `FIDC_MFR_ID : ((idx == 4'h1) ? `FIDC_MEM_TYPE : `FIDC_MEM_CAP);
    end else if (op == `FIDC_OP_QIO_ID) begin
      id_byte = (idx[0] ^ a0) ? `FIDC_DEV_ID : `FIDC_MFR_ID;
    end else begin
      id_byte = uid[8'(127 - 8 * idx) -: 8];
    end
  endfunction : id_byte

  always_comb begin
    logic [7:0] b;
    logic [3:0] lim;
    b = 8'h00;
    lim = 4'h0;
    n = q;
    n.refused = 1'b0;
    n.s_sclk = {q.s_sclk[0], lk.sclk};
    n.s_cs   = {q.s_cs[0], lk.cs_n};
    n.s_io   = {q.s_io[0], lk.io};
    n.sclk_d = sclk;
    // Self-timed cycle, frozen while suspended
    if (q.write_in_progress && !sus) begin
      if (q.timer == 12'h000) begin
        n.write_in_progress = 1'b0;
        n.op  = fidc_pkg::OP_NONE;
      end else begin
        n.timer = q.timer - 12'h001;
      end
    end
    if (q.write_in_progress && sus) begin
      if (q.lat == 10'h000) n.write_in_progress = 1'b0;
      else n.lat = q.lat - 10'h001;
    end
    if (!q.write_in_progress && !sus && array_prog_start_i) begin
      n.write_in_progress = 1'b1;
      n.op = fidc_pkg::OP_PROG;
      n.timer = 12'(`FIDC_PP_CYC);
    end else if (!q.write_in_progress && !sus && array_erase_start_i) begin
      n.write_in_progress = 1'b1;
      n.op = fidc_pkg::OP_ERASE;
      n.timer = 12'(`FIDC_SE_CYC);
    end
    if (cs_n) begin
      if (q.st == fidc_pkg::D_WAITCS) begin
        case (q.opc)
          `FIDC_OP_WRITE_ENABLE_CMD: if (!q.write_in_progress) n.write_enable_latch = 1'b1;
          `FIDC_OP_SUSP: begin
            if (q.write_in_progress && !sus && (q.op == fidc_pkg::OP_PROG || q.op == fidc_pkg::OP_ERASE)) begin
              n.sus_p = (q.op == fidc_pkg::OP_PROG);
              n.sus_e = (q.op == fidc_pkg::OP_ERASE);
              n.lat = 10'(`FIDC_SUSP_CYC);
            end
          end
          `FIDC_OP_RESUME: begin
            if (sus && !q.write_in_progress) begin
              n.sus_p = 1'b0;
              n.sus_e = 1'b0;
              n.write_in_progress = 1'b1;
            end
          end
          `FIDC_OP_SR_ERASE: begin
            if (q.write_enable_latch && !q.write_in_progress && sec_ok && !lock) begin
              n.mem[sel] = '1;
              n.write_in_progress = 1'b1;
              n.write_enable_latch = 1'b0;
              n.op = fidc_pkg::OP_SERASE;
              n.timer = 12'(`FIDC_SE_CYC);
            end
          end
          default: ;
        endcase
      end else if (q.st == fidc_pkg::D_DIN && q.opc == `FIDC_OP_SR_PROG && q.nd && q.cnt == 5'h00
                   && q.write_enable_latch && !q.write_in_progress && sec_ok && !lock) begin
        n.write_in_progress = 1'b1;
        n.write_enable_latch = 1'b0;
        n.op = fidc_pkg::OP_SPROG;
        n.timer = 12'(`FIDC_PP_CYC);
      end
      n.st = fidc_pkg::D_IDLE;
      n.oe_n = 4'hF;
      n.cnt = 5'h00;
      n.nd = 1'b0;
      n.bidx = 4'h0;
    end else if (q.st == fidc_pkg::D_IDLE) begin
      n.st = fidc_pkg::D_OPC;
    end else if (rise) begin
      unique case (q.st)
        fidc_pkg::D_OPC: begin
          b = {q.sr[6:0], di[0]};
          n.sr = b;
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'h07) begin
            n.cnt = 5'h00;
            n.opc = b;
            n.quad = (b == `FIDC_OP_QIO_ID);
            if (blocked(b, q.sus_p, q.sus_e)) begin
              n.st = fidc_pkg::D_IGNORE;
              n.refused = 1'b1;
            end else begin
              case (b)
                `FIDC_OP_READ_IDENTITY_CMD: n.st = q.write_in_progress ? fidc_pkg::D_IGNORE : fidc_pkg::D_OUT;
                `FIDC_OP_QIO_ID, `FIDC_OP_UID, `FIDC_OP_SR_ERASE, `FIDC_OP_SR_PROG: n.st = fidc_pkg::D_ADDR;
                `FIDC_OP_WRITE_ENABLE_CMD, `FIDC_OP_SUSP, `FIDC_OP_RESUME: n.st = fidc_pkg::D_WAITCS;
                default: n.st = fidc_pkg::D_IGNORE;
              endcase
            end
          end
        end
        fidc_pkg::D_ADDR: begin
          n.addr = q.quad ? {q.addr[19:0], di} : {q.addr[22:0], di[0]};
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == (q.quad ? 5'h05 : 5'h17)) begin
            n.cnt = 5'h00;
            case (q.opc)
              `FIDC_OP_UID:      n.st = fidc_pkg::D_DUMMY;
              `FIDC_OP_SR_ERASE: n.st = fidc_pkg::D_WAITCS;
              `FIDC_OP_SR_PROG:  n.st = fidc_pkg::D_DIN;
              default:           n.st = fidc_pkg::D_OUT;
            endcase
          end
        end
        fidc_pkg::D_DUMMY: begin
          n.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'h07) begin
            n.cnt = 5'h00;
            n.st = fidc_pkg::D_OUT;
          end
        end
        fidc_pkg::D_DIN: begin
          b = {q.sr[6:0], di[0]};
          n.sr = b;
          n.cnt = {2'h0, q.cnt[2:0] + 3'h1};
          if (q.cnt[2:0] == 3'h7) begin
            n.nd = 1'b1;
            if (q.write_enable_latch && !q.write_in_progress && sec_ok && !lock) begin
              n.mem[sel][q.addr[8:0]] = q.mem[sel][q.addr[8:0]] & b;
            end
            n.addr[7:0] = q.addr[7:0] + 8'h01;
          end
        end
        fidc_pkg::D_WAITCS: n.st = fidc_pkg::D_IGNORE;
        fidc_pkg::D_IDLE, fidc_pkg::D_OUT, fidc_pkg::D_IGNORE: ;
      endcase
    end else if (fall && q.st == fidc_pkg::D_OUT) begin
      n.oe_n = q.quad ? 4'h0 : 4'b1101;
      if (q.cnt == 5'h00) begin
        b = id_byte(q.opc, q.addr[0], q.bidx);
        lim = (q.opc == `FIDC_OP_READ_IDENTITY_CMD) ? 4'h2 : ((q.opc == `FIDC_OP_UID) ? 4'hF : 4'h1);
        n.bidx = (q.bidx == lim) ? 4'h0 : q.bidx + 4'h1;
        if (q.quad) begin
          n.out = b[7:4];
          n.sr = {b[3:0], 4'h0};
          n.cnt = 5'h01;
        end else begin
          n.out[1] = b[7];
          n.sr = {b[6:0], 1'b0};
          n.cnt = 5'h07;
        end
      end else begin
        if (q.quad) begin
          n.out = q.sr[7:4];
          n.sr = {q.sr[3:0], 4'h0};
        end else begin
          n.out[1] = q.sr[7];
          n.sr = {q.sr[6:0], 1'b0};
        end
        n.cnt = q.cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{st: fidc_pkg::D_IDLE, op: fidc_pkg::OP_NONE, s_sclk: 2'h0, s_cs: 2'h3, s_io: 8'hFF,
             oe_n: 4'hF, mem: '1, default: '0};
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign lk.d_io_o          = q.out;
  assign lk.d_io_oe_n       = q.oe_n;
  assign write_in_progress_o  = q.write_in_progress;
  assign write_enable_latch_o = q.write_enable_latch;
  assign suspend_flags_o      = {q.sus_e, q.sus_p};
  assign cmd_refused_o        = q.refused;
endmodule : fidc_flash
`default_nettype wire

// ===== rtl/fidc_host.sv
// Host serial flash controller with APB command registers
`default_nettype none
`include "fidc_defines.svh"
module fidc_host (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial link
  fidc_link_if.host        lk
);
  fidc_pkg::fidc_host_t q;
  fidc_pkg::fidc_host_t n;
  logic       mapped;
  logic       wr;
  logic [7:0] nb;
  logic       tick;

  assign mapped = (paddr_i == `FIDC_REG_CMD) || (paddr_i == `FIDC_REG_ADDR) || (paddr_i == `FIDC_REG_WDATA)
                  || (paddr_i == `FIDC_REG_RDATA) || (paddr_i == `FIDC_REG_STATUS);
  assign wr   = psel_i && penable_i && pwrite_i;
  assign nb   = q.cmd[`FIDC_CMD_NB_LSB +: 8];
  assign tick = (q.div == `FIDC_SCLK_HALF - 3'h1);

  always_comb begin
    logic [23:0] s;
    logic        qd;
    logic        ld;
    s = q.sr;
    qd = 1'b0;
    ld = 1'b0;
    n = q;
    n.s_io = {q.s_io[0], lk.io};
    // Register access; prdata latched in setup phase
    if (psel_i && !penable_i) begin
      case (paddr_i)
        `FIDC_REG_CMD:    n.prdata = {8'h00, q.cmd};
        `FIDC_REG_ADDR:   n.prdata = {8'h00, q.addr};
        `FIDC_REG_WDATA:  n.prdata = {24'h000000, q.wdata};
        `FIDC_REG_RDATA:  n.prdata = q.rx;
        `FIDC_REG_STATUS: n.prdata = {31'h0, q.st != fidc_pkg::H_IDLE};
        default:          n.prdata = 32'h00000000;
      endcase
    end
    if (wr && q.st == fidc_pkg::H_IDLE) begin
      if (paddr_i == `FIDC_REG_ADDR) n.addr = pwdata_i[23:0];
      if (paddr_i == `FIDC_REG_WDATA) n.wdata = pwdata_i[7:0];
      if (paddr_i == `FIDC_REG_CMD) begin
        n.cmd = pwdata_i[23:0];
        n.st = fidc_pkg::H_OPC;
        n.cs_n = 1'b0;
        n.sclk = 1'b0;
        n.div = 3'h0;
        n.cnt = 11'd8;
        n.rx = 32'h00000000;
        n.out[0] = pwdata_i[7];
        n.sr = {pwdata_i[6:0], 17'h00000};
        n.oe_n = 4'b1110;
      end
    end else if (q.st != fidc_pkg::H_IDLE) begin
      n.div = tick ? 3'h0 : q.div + 3'h1;
      if (tick && q.st == fidc_pkg::H_GAP) begin
        n.cs_n = 1'b1;
        n.oe_n = 4'hF;
        n.st = fidc_pkg::H_IDLE;
      end else if (tick && !q.sclk) begin
        n.sclk = 1'b1;
        n.cnt = q.cnt - 11'd1;
      end else if (tick) begin
        n.sclk = 1'b0;
        // Sample late: synchroniser still holds the old bit at the rise
        if (q.st == fidc_pkg::H_DATA && !q.cmd[`FIDC_CMD_TX]) begin
          n.rx = q.cmd[`FIDC_CMD_QUAD] ? {q.rx[27:0], q.s_io[1]} : {q.rx[30:0], q.s_io[1][1]};
        end
        if (q.cnt != 11'd0) begin
          ld = 1'b1;
          qd = q.cmd[`FIDC_CMD_QUAD] && q.st == fidc_pkg::H_ADDR;
        end else if (q.st == fidc_pkg::H_OPC && q.cmd[`FIDC_CMD_ADDR]) begin
          n.st = fidc_pkg::H_ADDR;
          s = q.addr;
          ld = 1'b1;
          qd = q.cmd[`FIDC_CMD_QUAD];
          n.cnt = qd ? 11'd6 : 11'd24;
          n.oe_n = qd ? 4'h0 : 4'b1110;
        end else if ((q.st == fidc_pkg::H_OPC || q.st == fidc_pkg::H_ADDR) && q.cmd[`FIDC_CMD_DUMMY]) begin
          n.st = fidc_pkg::H_DUMMY;
          s = 24'h000000;
          ld = 1'b1;
          n.cnt = 11'd8;
          n.oe_n = 4'b1110;
        end else if (q.st != fidc_pkg::H_DATA && nb != 8'h00) begin
          n.st = fidc_pkg::H_DATA;
          if (q.cmd[`FIDC_CMD_TX]) begin
            s = {3{q.wdata}};
            ld = 1'b1;
            n.cnt = {nb, 3'h0};
            n.oe_n = 4'b1110;
          end else begin
            n.cnt = q.cmd[`FIDC_CMD_QUAD] ? {2'h0, nb, 1'b0} : {nb, 3'h0};
            n.oe_n = 4'hF;
          end
        end else begin
          n.st = fidc_pkg::H_GAP;
        end
        if (ld) begin
          if (qd) begin
            n.out = s[23:20];
            n.sr = {s[19:0], s[23:20]};
          end else begin
            n.out[0] = s[23];
            n.sr = {s[22:0], s[23]};
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{st: fidc_pkg::H_IDLE, cs_n: 1'b1, oe_n: 4'hF, s_io: 8'hFF, default: '0};
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign prdata_o     = q.prdata;
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i && penable_i && !mapped;
  assign lk.cs_n      = q.cs_n;
  assign lk.sclk      = q.sclk;
  assign lk.h_io_o    = q.out;
  assign lk.h_io_oe_n = q.oe_n;
endmodule : fidc_host
`default_nettype wire

// ===== rtl/_unused_placeholder_none.sv
// Empty source, holds no logic
`default_nettype none
`default_nettype wire

// ===== tb/fidc_link_monitor.sv
// Protocol checker for the serial flash link between both ends
`default_nettype none
module fidc_link_monitor (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  // Link signals
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic [3:0] h_io_o,
  input  wire logic [3:0] h_io_oe_n,
  input  wire logic [3:0] d_io_o,
  input  wire logic [3:0] d_io_oe_n,
  input  wire logic [3:0] io
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic [3:0] rises;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // Rising serial clock edges since select, saturating at eight
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b0;
      rises  <= 4'h0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) rises <= 4'h0;
      else if (sclk && !sclk_q && rises != 4'h8) rises <= rises + 4'h1;
    end
  end

  chk_no_contention: assert property ((~h_io_oe_n & ~d_io_oe_n) == 4'h0)
    else $error("both ends drive one line");
  chk_idle_sclk_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  chk_sclk_high_width: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  chk_sclk_low_width: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("serial clock low phase short");
  chk_host_holds_data: assert property ((sclk && $past(sclk) && $stable(h_io_oe_n)) |->
    $stable(h_io_o | h_io_oe_n)) else $error("host data moved while clock high");
  chk_flash_holds_data: assert property ((sclk && $past(sclk) && $stable(d_io_oe_n)) |->
    $stable(d_io_o | d_io_oe_n)) else $error("flash data moved while clock high");
  chk_opcode_quiet: assert property ((!cs_n && rises < 4'h8) |-> d_io_oe_n == 4'hF)
    else $error("flash drives during opcode");
  chk_flash_lanes: assert property (d_io_oe_n inside {4'hF, 4'hD, 4'h0})
    else $error("flash drives odd lane set");
  chk_release_on_cs: assert property ($rose(cs_n) |-> ##[0:6] d_io_oe_n == 4'hF)
    else $error("flash keeps driving after deselect");

  cov_quad_out: cover property (d_io_oe_n == 4'h0 && io != 4'hF);
  cov_cs_cut: cover property ($rose(cs_n) && d_io_oe_n == 4'hD);
  cov_quad_addr: cover property (rises == 4'h8 && h_io_oe_n == 4'h0);
endmodule : fidc_link_monitor
`default_nettype wire

// ===== tb/flash_id_suspend_secreg_cmds_test.sv
// Testbench joining host controller and flash command block
`default_nettype none
`include "fidc_defines.svh"
module flash_id_suspend_secreg_cmds_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk_i   = 1'b0;
  logic         arst_n_i = 1'b0;
  logic         psel     = 1'b0;
  logic         penable  = 1'b0;
  logic         pwrite   = 1'b0;
  logic [7:0]   paddr    = 8'h00;
  logic [31:0]  pwdata   = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [2:0]   lock     = 3'h0;
  logic         prog_go  = 1'b0;
  logic         erase_go = 1'b0;
  logic         write_in_progress;
  logic         write_enable_latch;
  logic [1:0]   sus;
  logic         refused;
  int           errors      = 0;
  int           comparisons = 0;
  int           refusals    = 0;
  logic [31:0]  rd;
  logic         err;
  logic [31:0]  seed = 32'h7921;
  logic [127:0] uid  = `FIDC_UID;
  logic [31:0]  exp_q[$];
  logic [7:0]   ops[10] = '{8'h01, 8'h44, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h42, 8'h02, 8'h32};

  fidc_link_if i_fidc_link_if ();
  fidc_host i_fidc_host (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .lk(i_fidc_link_if.host));
  fidc_flash i_fidc_flash (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .lk(i_fidc_link_if.dev),
    .otp_lock_bits_i(lock), .array_prog_start_i(prog_go), .array_erase_start_i(erase_go),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .suspend_flags_o(sus), .cmd_refused_o(refused));
  fidc_link_monitor i_fidc_link_monitor (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cs_n(i_fidc_link_if.cs_n),
    .sclk(i_fidc_link_if.sclk), .h_io_o(i_fidc_link_if.h_io_o), .h_io_oe_n(i_fidc_link_if.h_io_oe_n),
    .d_io_o(i_fidc_link_if.d_io_o), .d_io_oe_n(i_fidc_link_if.d_io_oe_n), .io(i_fidc_link_if.io));

  initial forever #20 mclk_i = ~mclk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issue one link command and wait for the controller to go idle
  task automatic run(input logic [31:0] cmd, input logic [23:0] a, input logic [7:0] d);
    apb(1'b1, `FIDC_REG_ADDR, {8'h00, a});
    apb(1'b1, `FIDC_REG_WDATA, {24'h0, d});
    apb(1'b1, `FIDC_REG_CMD, cmd);
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, `FIDC_REG_STATUS, 32'h0);
    repeat (4) @(posedge mclk_i);
  endtask : run

  task automatic op(input logic [7:0] opc);
    run({24'h0, opc}, 24'h0, 8'h00);
  endtask : op

  task automatic expect_rx(input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, `FIDC_REG_RDATA, 32'h0);
  endtask : expect_rx

  task automatic wait_wip(input logic v, input int n);
    repeat (n) if (write_in_progress !== v) @(posedge mclk_i);
    check("write_in_progress", {31'h0, v}, {31'h0, write_in_progress});
  endtask : wait_wip

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Received word checker, oldest note first
  always @(posedge mclk_i) begin
    if (psel && penable && !pwrite && paddr == `FIDC_REG_RDATA && exp_q.size() > 0)
      check("rdata", exp_q.pop_front(), prdata);
  end

  always @(posedge mclk_i) if (refused === 1'b1) refusals++;

  initial begin
    #(40 * 80000);
    errors++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    run(32'h0004009F, 24'h0, 8'h00);
    expect_rx({`FIDC_MFR_ID, `FIDC_MEM_TYPE, `FIDC_MEM_CAP, `FIDC_MFR_ID});
    run(32'h00040394, 24'h0, 8'h00);
    expect_rx({2{`FIDC_MFR_ID, `FIDC_DEV_ID}});
    run(32'h00040394, 24'h1, 8'h00);
    expect_rx({2{`FIDC_DEV_ID, `FIDC_MFR_ID}});
    run(32'h0010054B, 24'h0, 8'h00);
    expect_rx(uid[31:0]);
    run(32'h0002009F, 24'h0, 8'h00);
    expect_rx({16'h0000, `FIDC_MFR_ID, `FIDC_MEM_TYPE});
    apb(1'b0, 8'h20, 32'h0);
    check("pslverr", 32'h1, {31'h0, err});
    check("unmapped", 32'h0, rd);
    // Security register program at a random byte of a random register
    seed = lfsr(seed);
    op(8'h06);
    check("wel", 32'h1, {31'h0, write_enable_latch});
    run(32'h00010942, {8'h00, 4'(seed[1:0] % 2'h3) + 4'h1, 3'h0, seed[12:4]}, seed[23:16]);
    wait_wip(1'b1, 20);
    check("wel", 32'h0, {31'h0, write_enable_latch});
    wait_wip(1'b0, 700);
    lock <= 3'b010;
    op(8'h06);
    run(32'h00000144, 24'h002000, 8'h00);
    wait_wip(1'b0, 20);
    run(32'h00010942, 24'h002010, seed[31:24]);
    wait_wip(1'b0, 20);
    run(32'h00010944, 24'h001000, 8'hFF);
    wait_wip(1'b0, 20);
    check("wel", 32'h1, {31'h0, write_enable_latch});
    run(32'h00000144, 24'h003200, 8'h00);
    wait_wip(1'b0, 20);
    run(32'h00000144, 24'h001000, 8'h00);
    wait_wip(1'b1, 20);
    run(32'h0004009F, 24'h0, 8'h00);
    expect_rx(32'hFFFFFFFF);
    op(8'h75);
    check("suspend_flags", 32'h0, {30'h0, sus});
    wait_wip(1'b1, 1);
    wait_wip(1'b0, 1600);
    op(8'h75);
    check("suspend_flags", 32'h0, {30'h0, sus});
    op(8'h7A);
    wait_wip(1'b0, 1);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk_i);
      erase_go <= (k != 1);
      prog_go  <= (k == 1);
      @(posedge mclk_i);
      erase_go <= 1'b0;
      prog_go  <= 1'b0;
      wait_wip(1'b1, 4);
      op(8'h75);
      check("suspend_flags", (k == 1) ? 32'h1 : 32'h2, {30'h0, sus});
      if (k == 2) break;
      wait_wip(1'b0, 520);
      refusals = 0;
      for (int j = 0; j < 10; j++) op(ops[j]);
      check("refusals", (k == 1) ? 32'd10 : 32'd7, refusals);
      check("suspend_flags", (k == 1) ? 32'h1 : 32'h2, {30'h0, sus});
      wait_wip(1'b0, 1);
      op(8'h7A);
      check("suspend_flags", 32'h0, {30'h0, sus});
      wait_wip(1'b1, 5);
      wait_wip(1'b0, 1600);
    end
    arst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    check("suspend_flags", 32'h0, {30'h0, sus});
    op(8'h7A);
    wait_wip(1'b0, 1);
    final_report();
  end
endmodule : flash_id_suspend_secreg_cmds_test
`default_nettype wire
